//--- core/osc_multiplier_control_defines.vh
/*
   Register map, field positions, reset values and timing counts for the
   oscillator trim and clock multiplier block.
   Assumes a 20 MHz reference clock and inclusion by bare name.
*/
`ifndef OSC_MULTIPLIER_CONTROL_DEFINES_VH
`define OSC_MULTIPLIER_CONTROL_DEFINES_VH

// ----------------------------------------------------------------------
// Register addresses
// ----------------------------------------------------------------------
`define ADDR_FINE_TRIM      8'h9e
`define ADDR_COARSE_TRIM    8'ha2
`define ADDR_MULT_CONTROL   8'h97

// ----------------------------------------------------------------------
// Multiplier control fields
// ----------------------------------------------------------------------
`define MC_ENABLE_BIT       7
`define MC_INIT_BIT         6
`define MC_LOCKED_BIT       5
`define MC_SCALE_HI         4
`define MC_SCALE_LO         2
`define MC_SOURCE_HI        1
`define MC_SOURCE_LO        0
`define MC_RESET            8'h00

// ----------------------------------------------------------------------
// Source select codes
// ----------------------------------------------------------------------
`define SRC_INT_HALF        2'h0
`define SRC_EXT_HALF        2'h1

// ----------------------------------------------------------------------
// Factory trim reset values
// ----------------------------------------------------------------------
`define COARSE_RESET        7'h40
`define FINE_RESET          6'h20

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define REF_CLK_MHZ         20
`define LOCK_TIME_NS        10000
// Lock time at the reference rate, sized for the 16-bit lock counter
`define LOCK_CYCLES         16'h00c8
`define OSC_SLOWEST_PERIOD  8'hc8
`define BURST_PULSES        3'h4
`define FAST_SPACING        16'h0002
`define SLOW_INPUT_PERIOD   16'h0100

`endif

//--- core/mult_scaler.v
/*
   Output scaler of the clock multiplier: passes 2 of every N base pulses,
   or every pulse for factor 1.
   Assumes base pulses are one-cycle strobes on the reference clock.
*/
`timescale 1ns/1ns
module mult_scaler
(
   input  wire       ref_clk_i,
   input  wire       reset_n_i,
   input  wire       clk_en_i,
   input  wire       clear_i,
   input  wire       pulse_i,
   input  wire [2:0] scale_i,
   output reg        pulse_o
);

   reg  [2:0] phase_q;
   reg  [2:0] phase_d;
   reg  [2:0] limit;
   wire       pass_all;

   // ---------------------------------------------------------------
   // Scale decode
   // ---------------------------------------------------------------
   assign pass_all = (scale_i[2:1] == 2'h0);

   always @*
   begin
      case (scale_i)
         3'h2:    limit = 3'h3;
         3'h4:    limit = 3'h4;
         3'h5:    limit = 3'h5;
         3'h6:    limit = 3'h6;
         3'h7:    limit = 3'h7;
         default: limit = 3'h1;
      endcase
   end

   always @*
   begin
      if (phase_q + 3'h1 >= limit)
         phase_d = 3'h0;
      else
         phase_d = phase_q + 3'h1;
   end

   // ---------------------------------------------------------------
   // Pulse gating; uneven patterns give non-50% duty
   // ---------------------------------------------------------------
   always @(posedge ref_clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         phase_q <= 3'h0;
         pulse_o <= 1'b0;
      end
      else if (clk_en_i)
      begin
         if (clear_i)
         begin
            phase_q <= 3'h0;
            pulse_o <= 1'b0;
         end
         else
         begin
            pulse_o <= pulse_i & (pass_all | (phase_q < 3'h2));
            if (pulse_i)
               phase_q <= pass_all ? 3'h0 : phase_d;
         end
      end
   end

endmodule // mult_scaler

//--- core/osc_trim_multiplier_control.v
/*
   Oscillator trim registers and clock multiplier model. The internal oscillator and
   multiplier output appear as one-cycle tick strobes on the reference clock.
   Assumes register strobes and ext_osc_i are synchronous to ref_clk_i.
*/
`timescale 1ns/1ns
`include "osc_multiplier_control_defines.vh"

// Behaviour
// - Coarse trim bit 7 reads zero, writes to it are ignored.
// - Coarse trim monotonic: zero slowest, all ones fastest.
// - Reset loads factory trims giving nominal oscillator rate.
// - Fine trim holds six bits; upper two read zero.
// - Multiplier gives four times input, scaled by programmed factor.
// - Input: external direct, internal halved or external halved.
// - Base outputs: internal x2, external x2, external x4.
// - Slow input: four fast pulses, then hold until next rise.
// - Locked flag reads one only after lock, else zero.
// - Scale decode: 0,1 x1; 2 2/3; 4 1/2; 5 2/5; 6 1/3; 7 2/7.
// - Source code 00 internal x2, 01 external x2.
module osc_trim_multiplier_control
#(
   parameter [6:0]  COARSE_FACTORY = `COARSE_RESET,
   parameter [6:0]  FINE_FACTORY_X = {1'b0, `FINE_RESET},
   parameter [15:0] LOCK_COUNT     = `LOCK_CYCLES
)
(
   input  wire       ref_clk_i,
   input  wire       reset_n_i,
   input  wire       clk_en_i,
   input  wire [7:0] reg_addr_i,
   input  wire       reg_wr_i,
   input  wire [7:0] reg_wdata_i,
   output reg  [7:0] reg_rdata_o,
   input  wire       ext_osc_i,
   output reg        int_osc_tick_o,
   output wire       mult_tick_o,
   output wire       mult_locked_o
);

   reg  [6:0]  coarse_trim_q;
   reg  [5:0]  fine_trim_q;
   reg         multiplier_enable_q;
   reg         multiplier_init_q;
   reg  [2:0]  multiplier_scale_q;
   reg  [1:0]  multiplier_source_q;
   reg         multiplier_locked_q;
   reg  [15:0] lock_cnt_q;
   reg  [7:0]  osc_cnt_q;
   reg  [7:0]  osc_period;
   reg         int_half_q;
   reg         ext_lvl_q;
   reg         ext_half_q;
   reg         sel_lvl;
   reg         sel_prev_q;
   reg  [15:0] per_cnt_q;
   reg  [15:0] spacing_q;
   reg  [15:0] gap_cnt_q;
   reg  [2:0]  burst_left_q;
   reg         base_pulse_q;
   wire        wr_coarse;
   wire        wr_fine;
   wire        wr_ctrl;
   wire        init_req;
   wire        off_req;
   wire        sel_rise;
   wire [15:0] new_spacing;

   // ------------------------------------------------------------------
   // Register decode
   // ------------------------------------------------------------------
   assign wr_coarse = reg_wr_i & (reg_addr_i == `ADDR_COARSE_TRIM);
   assign wr_fine   = reg_wr_i & (reg_addr_i == `ADDR_FINE_TRIM);
   assign wr_ctrl   = reg_wr_i & (reg_addr_i == `ADDR_MULT_CONTROL);
   // Init only counts while already enabled and enable kept set
   assign init_req  = wr_ctrl & multiplier_enable_q
                    & reg_wdata_i[`MC_ENABLE_BIT]
                    & reg_wdata_i[`MC_INIT_BIT];
   // Disable write drops lock at once, not a cycle late
   assign off_req   = wr_ctrl & ~reg_wdata_i[`MC_ENABLE_BIT];

   always @(posedge ref_clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         coarse_trim_q       <= COARSE_FACTORY;
         fine_trim_q         <= FINE_FACTORY_X[5:0];
         multiplier_enable_q <= 1'b0;
         multiplier_init_q   <= 1'b0;
         multiplier_scale_q  <= 3'h0;
         multiplier_source_q <= 2'h0;
      end
      else if (clk_en_i)
      begin
         if (wr_coarse)
            coarse_trim_q <= reg_wdata_i[6:0];
         if (wr_fine)
            fine_trim_q <= reg_wdata_i[5:0];
         if (wr_ctrl)
         begin
            multiplier_enable_q <= reg_wdata_i[`MC_ENABLE_BIT];
            multiplier_scale_q  <= reg_wdata_i[`MC_SCALE_HI:`MC_SCALE_LO];
            multiplier_source_q <= reg_wdata_i[`MC_SOURCE_HI:`MC_SOURCE_LO];
            multiplier_init_q   <= init_req |
               (multiplier_init_q & reg_wdata_i[`MC_ENABLE_BIT]);
         end
      end
   end

   always @(posedge ref_clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
         reg_rdata_o <= 8'h00;
      else if (clk_en_i)
      begin
         case (reg_addr_i)
            `ADDR_COARSE_TRIM:  reg_rdata_o <= {1'b0, coarse_trim_q};
            `ADDR_FINE_TRIM:    reg_rdata_o <= {2'h0, fine_trim_q};
            `ADDR_MULT_CONTROL: reg_rdata_o <= {multiplier_enable_q,
                                                multiplier_init_q,
                                                multiplier_locked_q,
                                                multiplier_scale_q,
                                                multiplier_source_q};
            default:            reg_rdata_o <= 8'h00;
         endcase
      end
   end

   // ------------------------------------------------------------------
   // Internal oscillator model
   // ------------------------------------------------------------------
   // Larger trim shortens the period; fine steps are summed in too
   always @*
   begin
      osc_period = `OSC_SLOWEST_PERIOD - {1'b0, coarse_trim_q}
                 - {2'h0, fine_trim_q};
   end

   always @(posedge ref_clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         osc_cnt_q      <= 8'h00;
         int_osc_tick_o <= 1'b0;
         int_half_q     <= 1'b0;
      end
      else if (clk_en_i)
      begin
         int_osc_tick_o <= 1'b0;
         if (osc_cnt_q + 8'h01 >= osc_period)
         begin
            osc_cnt_q      <= 8'h00;
            int_osc_tick_o <= 1'b1;
            // One level change per tick halves the oscillator
            int_half_q     <= ~int_half_q;
         end
         else
            osc_cnt_q <= osc_cnt_q + 8'h01;
      end
   end

   // ------------------------------------------------------------------
   // External oscillator and source select
   // ------------------------------------------------------------------
   always @(posedge ref_clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         ext_lvl_q  <= 1'b0;
         ext_half_q <= 1'b0;
         sel_prev_q <= 1'b0;
      end
      else if (clk_en_i)
      begin
         ext_lvl_q <= ext_osc_i;
         if (ext_osc_i & ~ext_lvl_q)
            ext_half_q <= ~ext_half_q;
         sel_prev_q <= sel_lvl;
      end
   end

   // Code 1x takes the external clock undivided, giving x4
   always @*
   begin
      case (multiplier_source_q)
         `SRC_INT_HALF: sel_lvl = int_half_q;
         `SRC_EXT_HALF: sel_lvl = ext_half_q;
         default:       sel_lvl = ext_lvl_q;
      endcase
   end

   assign sel_rise = sel_lvl & ~sel_prev_q;

   // ------------------------------------------------------------------
   // Lock tracking
   // ------------------------------------------------------------------
   always @(posedge ref_clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         lock_cnt_q          <= 16'h0000;
         multiplier_locked_q <= 1'b0;
      end
      else if (clk_en_i)
      begin
         if (!multiplier_enable_q | init_req | off_req)
         begin
            lock_cnt_q          <= 16'h0000;
            multiplier_locked_q <= 1'b0;
         end
         else if (multiplier_init_q & ~multiplier_locked_q)
         begin
            if (lock_cnt_q + 16'h0001 >= LOCK_COUNT)
               multiplier_locked_q <= 1'b1;
            else
               lock_cnt_q <= lock_cnt_q + 16'h0001;
         end
      end
   end

   assign mult_locked_o = multiplier_locked_q;

   // ------------------------------------------------------------------
   // Times four burst generator
   // ------------------------------------------------------------------
   // Spacing follows the last input period; too slow an input falls
   // back to a fixed fast spacing and the burst then waits
   assign new_spacing = (per_cnt_q > `SLOW_INPUT_PERIOD) ? `FAST_SPACING
                      : ((per_cnt_q[15:2] == 14'h0000) ? 16'h0001
                      : {2'h0, per_cnt_q[15:2]});

   always @(posedge ref_clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         per_cnt_q    <= 16'h0000;
         spacing_q    <= 16'h0001;
         gap_cnt_q    <= 16'h0000;
         burst_left_q <= 3'h0;
         base_pulse_q <= 1'b0;
      end
      else if (clk_en_i)
      begin
         base_pulse_q <= 1'b0;
         if (!multiplier_locked_q)
         begin
            per_cnt_q    <= 16'h0000;
            burst_left_q <= 3'h0;
         end
         else if (sel_rise)
         begin
            per_cnt_q    <= 16'h0001;
            spacing_q    <= new_spacing;
            gap_cnt_q    <= 16'h0000;
            burst_left_q <= `BURST_PULSES;
         end
         else
         begin
            if (per_cnt_q != 16'hffff)
               per_cnt_q <= per_cnt_q + 16'h0001;
            if (burst_left_q != 3'h0)
            begin
               if (gap_cnt_q == 16'h0000)
               begin
                  base_pulse_q <= 1'b1;
                  burst_left_q <= burst_left_q - 3'h1;
                  gap_cnt_q    <= spacing_q - 16'h0001;
               end
               else
                  gap_cnt_q <= gap_cnt_q - 16'h0001;
            end
         end
      end
   end

   // ------------------------------------------------------------------
   // Output scaling
   // ------------------------------------------------------------------
   mult_scaler u_scaler
   (
      .ref_clk_i (ref_clk_i),
      .reset_n_i (reset_n_i),
      .clk_en_i  (clk_en_i),
      .clear_i   (~multiplier_locked_q),
      .pulse_i   (base_pulse_q),
      .scale_i   (multiplier_scale_q),
      .pulse_o   (mult_tick_o)
   );

endmodule // osc_trim_multiplier_control

//--- sim/osc_trim_multiplier_control_checker.sv
/*
   Port assertions for the oscillator trim and clock multiplier block.
   Assumes binding to osc_trim_multiplier_control; sees only its ports.
*/
`timescale 1ns/1ns
module osc_trim_multiplier_control_checker
#(
   parameter [15:0] LOCK_COUNT = 16'h00c8
)
(
   input wire       ref_clk_i,
   input wire       reset_n_i,
   input wire       clk_en_i,
   input wire [7:0] reg_addr_i,
   input wire       reg_wr_i,
   input wire [7:0] reg_wdata_i,
   input wire [7:0] reg_rdata_o,
   input wire       ext_osc_i,
   input wire       int_osc_tick_o,
   input wire       mult_tick_o,
   input wire       mult_locked_o
);
   // ------------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------------
   // Ticks in flight may drain a few cycles after lock drops
   reg  [3:0]  idle_q;
   reg  [15:0] age_q;
   wire        ctl_wr = clk_en_i & reg_wr_i & (reg_addr_i == 8'h97);

   always @(posedge ref_clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         idle_q <= 4'hf;
         age_q  <= 16'h0000;
      end
      else
      begin
         if (mult_locked_o)
            idle_q <= 4'h0;
         else if (clk_en_i && idle_q != 4'hf)
            idle_q <= idle_q + 4'h1;
         if (ctl_wr && reg_wdata_i[7:6] == 2'h3)
            age_q <= 16'h0000;
         else if (clk_en_i && age_q != 16'hffff)
            age_q <= age_q + 16'h0001;
      end
   end

   // ------------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------------
   default clocking cb @(posedge ref_clk_i);
   endclocking
   default disable iff (!reset_n_i);

   sequence s_init_wr;
      ctl_wr && reg_wdata_i[7:6] == 2'h3;
   endsequence
   sequence s_off_wr;
      ctl_wr && !reg_wdata_i[7];
   endsequence
   sequence s_ctl_rd;
      clk_en_i && !reg_wr_i && reg_addr_i == 8'h97;
   endsequence

   a_coarse_top_zero: assert property
      (clk_en_i && reg_addr_i == 8'ha2 |=> !reg_rdata_o[7])
      else $error("coarse trim bit 7 not zero");
   a_fine_top_zero: assert property
      (clk_en_i && reg_addr_i == 8'h9e |=> reg_rdata_o[7:6] == 2'h0)
      else $error("fine trim bits 7:6 not zero");
   a_locked_mirrored: assert property
      (s_ctl_rd |=> reg_rdata_o[5] == $past(mult_locked_o))
      else $error("locked bit differs from locked output");
   a_init_drops_lock: assert property
      (s_init_wr |=> !mult_locked_o)
      else $error("locked kept after initialise");
   a_off_drops_lock: assert property
      (s_off_wr |=> !mult_locked_o)
      else $error("locked kept after disable");
   a_off_reads_zero: assert property
      (s_off_wr ##1 s_ctl_rd |=> reg_rdata_o[7:5] == 3'h0)
      else $error("control top bits set after disable");
   a_lock_timing: assert property
      ($rose(mult_locked_o) |->
         age_q >= LOCK_COUNT / 2 && age_q <= LOCK_COUNT + 16'h0004)
      else $error("lock rose outside its time");
   a_no_tick_unlocked: assert property
      (idle_q >= 4'h4 |-> !mult_tick_o)
      else $error("multiplier tick while unlocked");
endmodule // osc_trim_multiplier_control_checker

bind osc_trim_multiplier_control osc_trim_multiplier_control_checker
#(
   .LOCK_COUNT(LOCK_COUNT)
)
checker_inst
(
   .ref_clk_i      (ref_clk_i),
   .reset_n_i      (reset_n_i),
   .clk_en_i       (clk_en_i),
   .reg_addr_i     (reg_addr_i),
   .reg_wr_i       (reg_wr_i),
   .reg_wdata_i    (reg_wdata_i),
   .reg_rdata_o    (reg_rdata_o),
   .ext_osc_i      (ext_osc_i),
   .int_osc_tick_o (int_osc_tick_o),
   .mult_tick_o    (mult_tick_o),
   .mult_locked_o  (mult_locked_o)
);

//--- sim/osc_trim_multiplier_control_tb.sv
/*
   Self-checking bench for the trim and multiplier block.
   Assumes the checker file is compiled alongside; inputs move at negedge.
*/
`timescale 1ns/1ns
module osc_trim_multiplier_control_tb;
   // ------------------------------------------------------------------
   // Signals and instance
   // ------------------------------------------------------------------
   // Short lock count keeps the run brief
   localparam [15:0] LOCK_N = 16'h0008;
   reg        ref_clk_i;
   reg        reset_n_i;
   reg        clk_en_i;
   reg  [7:0] reg_addr_i;
   reg        reg_wr_i;
   reg  [7:0] reg_wdata_i;
   wire [7:0] reg_rdata_o;
   reg        ext_osc_i;
   wire       int_osc_tick_o;
   wire       mult_tick_o;
   wire       mult_locked_o;
   integer    mismatches;
   integer    tests_run;
   integer    cycles;
   integer    ext_half;
   integer    ext_cnt;
   integer    cm;
   integer    ci;
   integer    s;
   integer    n;

   osc_trim_multiplier_control #(.LOCK_COUNT(LOCK_N)) osc_trim_multiplier_control_inst
   (
      .ref_clk_i      (ref_clk_i),
      .reset_n_i      (reset_n_i),
      .clk_en_i       (clk_en_i),
      .reg_addr_i     (reg_addr_i),
      .reg_wr_i       (reg_wr_i),
      .reg_wdata_i    (reg_wdata_i),
      .reg_rdata_o    (reg_rdata_o),
      .ext_osc_i      (ext_osc_i),
      .int_osc_tick_o (int_osc_tick_o),
      .mult_tick_o    (mult_tick_o),
      .mult_locked_o  (mult_locked_o)
   );

   initial
   begin
      ref_clk_i = 1'b0;
      forever
         #25 ref_clk_i = ~ref_clk_i;
   end

   always @(negedge ref_clk_i)
   begin
      ext_cnt = ext_cnt + 1;
      if (ext_cnt >= ext_half)
      begin
         ext_cnt = 0;
         ext_osc_i = ~ext_osc_i;
      end
   end

   always @(posedge ref_clk_i)
   begin
      cycles = cycles + 1;
      if (cycles == 60000)
      begin
         mismatches = mismatches + 1;
         conclude;
      end
   end

   // ------------------------------------------------------------------
   // Shared tasks
   // ------------------------------------------------------------------
   task check(input [15:0] seen, input [15:0] exp, input string what);
   begin
      tests_run = tests_run + 1;
      if (seen !== exp)
      begin
         mismatches = mismatches + 1;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   end
   endtask

   task conclude;
   begin
      if (mismatches == 0 && tests_run > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   end
   endtask

   task wr(input [7:0] a, input [7:0] d);
   begin
      @(negedge ref_clk_i);
      reg_addr_i = a;
      reg_wdata_i = d;
      reg_wr_i = 1'b1;
      @(negedge ref_clk_i);
      reg_wr_i = 1'b0;
   end
   endtask

   task rd_chk(input [7:0] a, input [7:0] e, input string w);
   begin
      @(negedge ref_clk_i);
      reg_addr_i = a;
      @(negedge ref_clk_i);
      check(reg_rdata_o, e, w);
   end
   endtask

   task count(input integer len);
   begin
      cm = 0;
      ci = 0;
      repeat (len)
      begin
         @(negedge ref_clk_i);
         cm = cm + (mult_tick_o === 1'b1);
         ci = ci + (int_osc_tick_o === 1'b1);
      end
   end
   endtask

   // Skips two periods so a trim change mid-period is not measured
   task osc_period(input [15:0] e);
   begin
      repeat (3)
      begin
         n = 0;
         @(negedge ref_clk_i);
         while (int_osc_tick_o !== 1'b1 && n < 300)
         begin
            @(negedge ref_clk_i);
            n = n + 1;
         end
      end
      check(n + 1, e, "osc period");
   end
   endtask

   task mult_on(input [7:0] cfg);
   begin
      wr(8'h97, 8'h00);
      wr(8'h97, cfg);
      wr(8'h97, cfg | 8'h80);
      repeat (101) @(negedge ref_clk_i);
      wr(8'h97, cfg | 8'hc0);
      n = 0;
      while (mult_locked_o !== 1'b1 && n < 40)
      begin
         @(negedge ref_clk_i);
         n = n + 1;
      end
      check(n >= 3 && n <= 12, 1'b1, "lock time");
      rd_chk(8'h97, 8'he0 | cfg, "control");
      // Settle past one slow input period before counting
      repeat (620) @(negedge ref_clk_i);
   end
   endtask

   // ------------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------------
   task t_reset;
   begin
      rd_chk(8'ha2, 8'h40, "coarse");
      rd_chk(8'h9e, 8'h20, "fine");
      rd_chk(8'h97, 8'h00, "control");
      rd_chk(8'h55, 8'h00, "unmapped");
      osc_period(16'h0068);
   end
   endtask

   task t_trims;
   begin
      wr(8'ha2, 8'hff);
      rd_chk(8'ha2, 8'h7f, "coarse");
      wr(8'h9e, 8'hff);
      rd_chk(8'h9e, 8'h3f, "fine");
      osc_period(16'h000a);
      wr(8'ha2, 8'h00);
      wr(8'h9e, 8'h00);
      osc_period(16'h00c8);
   end
   endtask

   // Window of 420 base pulses divides by every scale denominator
   task t_scales;
   begin
      for (s = 0; s < 8; s = s + 1)
      begin
         if (s != 3)
         begin
            mult_on({3'h0, s[2:0], 2'h2});
            count(840);
            check(cm, 840 / (s < 2 ? 2 : s == 2 ? 3 : s), "ticks");
         end
      end
   end
   endtask

   task t_sources;
   begin
      for (s = 0; s < 4; s = s + 1)
      begin
         mult_on({6'h00, s[1:0]});
         count(s == 0 ? 1040 : 840);
         check(cm, s==0 ? 20 : s==1 ? 210 : 420, "src");
         // Internal x2: twice the oscillator ticks in the same window
         if (s == 0)
            check(ci, 10, "int ticks");
      end
   end
   endtask

   task t_slow;
   begin
      ext_half = 300;
      mult_on(8'h02);
      count(6000);
      check(cm, 40, "slow ticks");
      // Wait out the high phase so the first tick found opens a burst
      n = 0;
      while (ext_osc_i !== 1'b0 && n < 900)
      begin
         @(negedge ref_clk_i);
         n = n + 1;
      end
      while (mult_tick_o !== 1'b1 && n < 900)
      begin
         @(negedge ref_clk_i);
         n = n + 1;
      end
      check(n < 900, 1'b1, "burst found");
      repeat (3)
      begin
         repeat (2) @(negedge ref_clk_i);
         check(mult_tick_o, 1'b1, "burst");
      end
      repeat (2) @(negedge ref_clk_i);
      check(mult_tick_o, 1'b0, "hold");
      ext_half = 4;
   end
   endtask

   task t_ctrl;
   begin
      mult_on(8'h02);
      wr(8'h97, 8'hc2);
      check(mult_locked_o, 1'b0, "reinit");
      // Disable only after relock, so the drop is really tested
      repeat (12) @(negedge ref_clk_i);
      check(mult_locked_o, 1'b1, "relock");
      wr(8'h97, 8'h00);
      check(mult_locked_o, 1'b0, "disable");
      wr(8'h97, 8'hc4);
      rd_chk(8'h97, 8'h84, "early init");
      wr(8'h97, 8'ha4);
      rd_chk(8'h97, 8'h84, "ready ro");
      check(mult_locked_o, 1'b0, "no lock");
      clk_en_i = 1'b0;
      wr(8'ha2, 8'h11);
      clk_en_i = 1'b1;
      rd_chk(8'ha2, 8'h40, "frozen");
   end
   endtask

   initial
   begin
      reset_n_i = 1'b0;
      clk_en_i = 1'b1;
      reg_addr_i = 8'h00;
      reg_wr_i = 1'b0;
      reg_wdata_i = 8'h00;
      ext_osc_i = 1'b0;
      ext_half = 4;
      ext_cnt = 0;
      mismatches = 0;
      tests_run = 0;
      cycles = 0;
      repeat (12) @(negedge ref_clk_i);
      reset_n_i = 1'b1;
      t_reset;
      t_trims;
      reset_n_i = 1'b0;
      repeat (12) @(negedge ref_clk_i);
      reset_n_i = 1'b1;
      t_reset;
      t_scales;
      t_sources;
      t_slow;
      t_ctrl;
      conclude;
   end
endmodule // osc_trim_multiplier_control_tb
